// [verilog/mups_pkg.sv]
// constants, register map and types of the multi-unit program synchroniser
// What this block does
// RULE1 - flag on while waiting or time remains
// RULE2 - flag off when not waiting, time zero
// RULE3 - flag held off one second after transition
// RULE4 - flag off unless program pattern running
// RULE5 - flag off while group-one wait disabled
// RULE6 - wait input from configured relay code, off disables
// RULE7 - output code 4261 drives transition flag
// RULE8 - any unit waiting forces wait, no advance
// RULE9 - advance only when all flags off
// RULE10 - both modes use group-one wait parameters
// RULE11 - operator sets segments at least five seconds
// RULE12 - operator normally uses continue junction type
// RULE13 - hold input selectable, code 4190 drives wait flag
// RULE14 - any unit waiting forces hold
// RULE15 - hold released when all wait flags off
// RULE16 - program start delayed about five seconds
// RULE17 - flags wired-OR onto every unit's input
// RULE18 - sample input and update flags per tick
package mups_pkg;
    localparam int CODE_W = 13;
    localparam int DI_N = 13;
    localparam int DO_N = 7;
    // relay and function codes
    localparam logic [12:0] CODE_OFF = 13'h0000;
    localparam logic [12:0] CODE_STD_FIRST = 13'd5025;
    localparam logic [12:0] CODE_STD_LAST = 13'd5027;
    localparam logic [12:0] CODE_E1_FIRST = 13'd5041;
    localparam logic [12:0] CODE_E1_LAST = 13'd5045;
    localparam logic [12:0] CODE_E4_FIRST = 13'd5089;
    localparam logic [12:0] CODE_E4_LAST = 13'd5093;
    localparam logic [3:0] IDX_E1_BASE = 4'h3;
    localparam logic [3:0] IDX_E4_BASE = 4'h8;
    localparam logic [12:0] FN_SEG_FLAG = 13'd4261;
    localparam logic [12:0] FN_WAIT_FLAG = 13'd4190;
    // timing in whole seconds, one tick per second
    localparam int TICK_S = 1;
    localparam int START_DELAY_S = 5;
    localparam int BLANK_S = 1;
    localparam logic [2:0] START_TICKS = 3'(START_DELAY_S / TICK_S);
    localparam logic [2:0] BLANK_TICKS = 3'(BLANK_S / TICK_S);
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAIT_SEL = 8'h04;
    localparam logic [7:0] OFS_HOLD_SEL = 8'h08;
    localparam logic [7:0] OFS_WZONE = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_OUTFN0 = 8'h20;
    localparam logic [7:0] OFS_OUTFN_LAST = 8'h38;
    // field positions
    localparam int CTRL_WAIT_EN = 0;
    localparam int WZ_UP_LSB = 16;
    localparam int ST_SEG_FLAG = 0;
    localparam int ST_WAIT_FLAG = 1;
    localparam int ST_FORCE_WAIT = 2;
    localparam int ST_FORCE_HOLD = 3;
    localparam int ST_STARTED = 4;
    localparam int ST_BLANK = 5;
    localparam int ST_ADVANCE = 6;
    // reset values and ahb nonseq transfer type
    localparam logic RST_WAIT_EN = 1'b0;
    localparam logic [15:0] RST_WZ = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef struct packed {
        logic running;     // program pattern operation in progress
        logic remain_zero; // current segment remaining time is zero
        logic seg_wait;    // waiting at segment boundary, out of wait zone
        logic wait_flag;   // wait-in-interval flag of this unit
    } mups_seq_s;

    typedef struct packed {
        logic valid;
        logic [3:0] idx;
    } mups_disel_s;
endpackage

// [verilog/mups_sync.sv]
// multi-unit program synchroniser with ahb-lite register slave
//
// Chosen here: the AHB-Lite slave port and the register offsets.
module mups_sync (
    input wire logic CLK,                      // system clock, 100 MHz
    input wire logic RST,                      // async reset, active high
    input wire logic HSEL,                     // ahb slave select
    input wire logic [31:0] HADDR,             // ahb address
    input wire logic [1:0] HTRANS,             // ahb transfer type
    input wire logic HWRITE,                   // ahb write
    input wire logic [2:0] HSIZE,              // ahb size, word only
    input wire logic [31:0] HWDATA,            // ahb write data
    input wire logic HREADY,                   // ahb bus ready
    output logic [31:0] HRDATA,                // ahb read data
    output logic HREADYOUT,                    // ahb slave ready
    output logic HRESP,                        // ahb response, always okay
    input wire logic TICK,                     // one-second control tick pulse
    input wire mups_pkg::mups_seq_s SEQ,       // sequencer status
    input wire logic [12:0] DI,                // contact inputs, std, e1, e4
    output logic [6:0] CONTACT_OUT,            // alarm, relay and digital outputs
    output logic SEG_ADVANCE,                  // one-clock segment advance grant
    output logic FORCE_WAIT,                   // forced wait to sequencer
    output logic FORCE_HOLD,                   // forced hold to sequencer
    output logic RUN_PERMIT,                   // program may start
    output logic WAIT_ENABLE,                  // group-one wait enable
    output logic [15:0] WAIT_ZONE_UP,          // group-one wait zone upper
    output logic [15:0] WAIT_ZONE_LO           // group-one wait zone lower
);
    typedef struct packed {
        logic ready;
        logic wr;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic wait_en;
        logic [12:0] wait_sel;
        logic [12:0] hold_sel;
        logic [15:0] wz_up;
        logic [15:0] wz_lo;
        logic [6:0][12:0] outfn;
        logic [12:0] di;
        logic [2:0] start_cnt;
        logic started;
        logic [2:0] blank_cnt;
        logic seg_flag;
        logic wait_flag;
        logic force_wait;
        logic force_hold;
        logic advance;
        logic [6:0] cout;
    } mups_state_s;

    mups_state_s s_q;
    mups_state_s s_d;

    // relay code to contact input index
    function automatic mups_pkg::mups_disel_s di_decode(input logic [12:0] code);
        mups_pkg::mups_disel_s r;
        r.valid = 1'b0;
        r.idx = 4'h0;
        if (code >= mups_pkg::CODE_STD_FIRST && code <= mups_pkg::CODE_STD_LAST) begin
            r.valid = 1'b1;
            r.idx = 4'(code - mups_pkg::CODE_STD_FIRST);
        end else if (code >= mups_pkg::CODE_E1_FIRST && code <= mups_pkg::CODE_E1_LAST) begin
            r.valid = 1'b1;
            r.idx = 4'(code - mups_pkg::CODE_E1_FIRST) + mups_pkg::IDX_E1_BASE;
        end else if (code >= mups_pkg::CODE_E4_FIRST && code <= mups_pkg::CODE_E4_LAST) begin
            r.valid = 1'b1;
            r.idx = 4'(code - mups_pkg::CODE_E4_FIRST) + mups_pkg::IDX_E4_BASE;
        end
        return r;
    endfunction

    // register read view of a state
    function automatic logic [31:0] reg_read(input mups_state_s s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == mups_pkg::OFS_CTRL) begin
            r[mups_pkg::CTRL_WAIT_EN] = s.wait_en;
        end else if (a == mups_pkg::OFS_WAIT_SEL) begin
            r[12:0] = s.wait_sel;
        end else if (a == mups_pkg::OFS_HOLD_SEL) begin
            r[12:0] = s.hold_sel;
        end else if (a == mups_pkg::OFS_WZONE) begin
            r = {s.wz_up, s.wz_lo};
        end else if (a == mups_pkg::OFS_STATUS) begin
            r[mups_pkg::ST_SEG_FLAG] = s.seg_flag;
            r[mups_pkg::ST_WAIT_FLAG] = s.wait_flag;
            r[mups_pkg::ST_FORCE_WAIT] = s.force_wait;
            r[mups_pkg::ST_FORCE_HOLD] = s.force_hold;
            r[mups_pkg::ST_STARTED] = s.started;
            r[mups_pkg::ST_BLANK] = (s.blank_cnt != 3'h0);
            r[mups_pkg::ST_ADVANCE] = s.advance;
        end else if (a >= mups_pkg::OFS_OUTFN0 && a <= mups_pkg::OFS_OUTFN_LAST
                     && a[1:0] == 2'b00) begin
            r[12:0] = s.outfn[3'((a - mups_pkg::OFS_OUTFN0) >> 2)];
        end
        return r;
    endfunction

    mups_pkg::mups_disel_s wsel;
    mups_pkg::mups_disel_s hsel;
    logic active;
    logic wait_in;
    logic hold_in;
    logic adv_now;

    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b1;
        s_d.advance = 1'b0;
        // write data phase
        if (s_q.wr) begin
            if (s_q.addr == mups_pkg::OFS_CTRL) begin
                s_d.wait_en = HWDATA[mups_pkg::CTRL_WAIT_EN];
            end else if (s_q.addr == mups_pkg::OFS_WAIT_SEL) begin
                s_d.wait_sel = HWDATA[12:0];
            end else if (s_q.addr == mups_pkg::OFS_HOLD_SEL) begin
                s_d.hold_sel = HWDATA[12:0];
            end else if (s_q.addr == mups_pkg::OFS_WZONE) begin
                s_d.wz_up = HWDATA[31:mups_pkg::WZ_UP_LSB];
                s_d.wz_lo = HWDATA[15:0];
            end else if (s_q.addr >= mups_pkg::OFS_OUTFN0
                         && s_q.addr <= mups_pkg::OFS_OUTFN_LAST
                         && s_q.addr[1:0] == 2'b00) begin
                s_d.outfn[3'((s_q.addr - mups_pkg::OFS_OUTFN0) >> 2)] = HWDATA[12:0];
            end
        end
        // per-tick synchronisation
        wsel = di_decode(s_q.wait_sel); // RULE6
        hsel = di_decode(s_q.hold_sel); // RULE13
        active = SEQ.running && s_q.started;
        wait_in = wsel.valid && DI[wsel.idx]; // RULE17
        hold_in = hsel.valid && DI[hsel.idx]; // RULE17
        adv_now = 1'b0;
        if (TICK) begin // RULE18
            s_d.di = DI;
            if (!s_q.started) begin
                if (s_q.start_cnt + 3'h1 >= mups_pkg::START_TICKS) begin // RULE16
                    s_d.started = 1'b1;
                end
                s_d.start_cnt = s_q.start_cnt + 3'h1;
            end
            if (s_q.blank_cnt != 3'h0) begin
                s_d.blank_cnt = s_q.blank_cnt - 3'h1;
            end
            // advance only when the wired-or of all flags is low
            if (active && SEQ.remain_zero && !SEQ.seg_wait && !wait_in) begin // RULE9
                adv_now = 1'b1;
            end
            s_d.advance = adv_now;
            if (adv_now) begin
                s_d.blank_cnt = mups_pkg::BLANK_TICKS; // RULE3
            end
            // flag off when idle, disabled or blanking
            s_d.seg_flag = active && s_q.wait_en && !adv_now // RULE4 RULE5 RULE10
                && s_q.blank_cnt == 3'h0 // RULE3
                && (SEQ.seg_wait || !SEQ.remain_zero); // RULE1 RULE2
            s_d.force_wait = active && wait_in; // RULE8
            s_d.force_hold = active && hold_in; // RULE14 RULE15
            s_d.wait_flag = active && s_q.wait_en && SEQ.wait_flag; // RULE10
        end
        for (int i = 0; i < mups_pkg::DO_N; i++) begin
            if (s_d.outfn[i] == mups_pkg::FN_SEG_FLAG) begin
                s_d.cout[i] = s_d.seg_flag; // RULE7
            end else if (s_d.outfn[i] == mups_pkg::FN_WAIT_FLAG) begin
                s_d.cout[i] = s_d.wait_flag; // RULE13
            end else begin
                s_d.cout[i] = 1'b0;
            end
        end
        // address phase
        s_d.wr = 1'b0;
        if (HSEL && HREADY && HTRANS == mups_pkg::HTRANS_NONSEQ) begin
            s_d.addr = HADDR[7:0];
            s_d.wr = HWRITE;
            if (!HWRITE) begin
                s_d.rdata = reg_read(s_d, HADDR[7:0]);
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
            s_q.wait_en <= mups_pkg::RST_WAIT_EN;
            s_q.wz_up <= mups_pkg::RST_WZ;
            s_q.wz_lo <= mups_pkg::RST_WZ;
        end else begin
            s_q <= s_d;
        end
    end

    assign HRDATA = s_q.rdata;
    assign HREADYOUT = s_q.ready;
    assign HRESP = 1'b0;
    assign CONTACT_OUT = s_q.cout;
    assign SEG_ADVANCE = s_q.advance;
    assign FORCE_WAIT = s_q.force_wait;
    assign FORCE_HOLD = s_q.force_hold;
    assign RUN_PERMIT = s_q.started;
    assign WAIT_ENABLE = s_q.wait_en;
    assign WAIT_ZONE_UP = s_q.wz_up;
    assign WAIT_ZONE_LO = s_q.wz_lo;

    property p_idle_flag_off;
        @(posedge CLK) disable iff (RST)
        TICK && !SEQ.running |=> !s_q.seg_flag && !FORCE_WAIT && !FORCE_HOLD;
    endproperty
    a_idle_flag_off: assert property (p_idle_flag_off) // RULE4
        else $error("transition flag set while not running");

    property p_disabled_flag_off;
        @(posedge CLK) disable iff (RST)
        TICK && !s_q.wait_en |=> !s_q.seg_flag;
    endproperty
    a_disabled_flag_off: assert property (p_disabled_flag_off) // RULE5
        else $error("transition flag set while wait disabled");

    property p_flag_on;
        @(posedge CLK) disable iff (RST)
        TICK && active && s_q.wait_en && s_q.blank_cnt == 3'h0 && !SEQ.remain_zero
        |=> s_q.seg_flag;
    endproperty
    a_flag_on: assert property (p_flag_on) // RULE1
        else $error("transition flag not set with time remaining");

    property p_flag_off_zero;
        @(posedge CLK) disable iff (RST)
        TICK && SEQ.remain_zero && !SEQ.seg_wait |=> !s_q.seg_flag;
    endproperty
    a_flag_off_zero: assert property (p_flag_off_zero) // RULE2
        else $error("transition flag set with zero remaining time");

    property p_blank_after_advance;
        @(posedge CLK) disable iff (RST)
        SEG_ADVANCE |-> !s_q.seg_flag && s_q.blank_cnt != 3'h0;
    endproperty
    a_blank_after_advance: assert property (p_blank_after_advance) // RULE3
        else $error("transition flag not held off after advance");

    property p_blank_hold;
        @(posedge CLK) disable iff (RST)
        TICK && s_q.blank_cnt != 3'h0 |=> !s_q.seg_flag;
    endproperty
    a_blank_hold: assert property (p_blank_hold) // RULE3
        else $error("transition flag raised within blank second");

    property p_out_code;
        @(posedge CLK) disable iff (RST)
        s_q.outfn[2] == mups_pkg::FN_SEG_FLAG |-> CONTACT_OUT[2] == s_q.seg_flag;
    endproperty
    a_out_code: assert property (p_out_code) // RULE7
        else $error("contact output does not follow transition flag");

    property p_forced_wait;
        @(posedge CLK) disable iff (RST)
        TICK && active && wait_in |=> FORCE_WAIT && !SEG_ADVANCE;
    endproperty
    a_forced_wait: assert property (p_forced_wait) // RULE8
        else $error("peer wait did not force wait");

    property p_advance_clear;
        @(posedge CLK) disable iff (RST)
        SEG_ADVANCE |-> !FORCE_WAIT && $past(TICK) && !$past(wait_in);
    endproperty
    a_advance_clear: assert property (p_advance_clear) // RULE9
        else $error("advance granted while a flag was set");

    property p_forced_hold;
        @(posedge CLK) disable iff (RST)
        TICK && active && hsel.valid |=> FORCE_HOLD == $past(hold_in);
    endproperty
    a_forced_hold: assert property (p_forced_hold) // RULE14 RULE15
        else $error("hold does not follow peer wait");

    property p_start_delay;
        @(posedge CLK) disable iff (RST)
        !RUN_PERMIT |-> s_q.start_cnt < mups_pkg::START_TICKS && !SEG_ADVANCE;
    endproperty
    a_start_delay: assert property (p_start_delay) // RULE16
        else $error("program permitted before start delay");
endmodule

// [sim/mups_peer.sv]
// model of the peer controllers on the wired-or synchronisation contact line
module mups_peer (
    input wire logic clk,            // system clock
    input wire logic rst,            // async reset, active high
    input wire logic tick,           // one-second control tick
    input wire logic own_flag,       // this unit's flag contact output
    input wire logic peer_req,       // flag the peers are told to show
    input wire logic [3:0] line_idx, // contact input the line is wired to
    output logic [12:0] di           // contact inputs of the unit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic peer_q;
    // peers move their flags only on the tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peer_q <= 1'h0;
        end else if (tick) begin
            peer_q <= peer_req;
        end
    end
    // open contacts read low; the line is an or of all units' flags
    assign di = 13'(peer_q | own_flag) << line_idx;
endmodule

// [sim/mups_sync_tb.sv]
// self-checking bench of the multi-unit program synchroniser
module mups_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, TICK, peer_req, adv;
    logic SEG_ADVANCE, FORCE_WAIT, FORCE_HOLD, RUN_PERMIT, WAIT_ENABLE;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [15:0] WAIT_ZONE_UP, WAIT_ZONE_LO;
    logic [12:0] DI;
    logic [6:0] CONTACT_OUT;
    logic [3:0] line_idx;
    mups_pkg::mups_seq_s SEQ;
    int fail_count, checks;
    assign HREADY = HREADYOUT;
    mups_sync mups_sync_i (
        .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TICK(TICK),
        .SEQ(SEQ), .DI(DI), .CONTACT_OUT(CONTACT_OUT), .SEG_ADVANCE(SEG_ADVANCE),
        .FORCE_WAIT(FORCE_WAIT), .FORCE_HOLD(FORCE_HOLD), .RUN_PERMIT(RUN_PERMIT),
        .WAIT_ENABLE(WAIT_ENABLE), .WAIT_ZONE_UP(WAIT_ZONE_UP),
        .WAIT_ZONE_LO(WAIT_ZONE_LO)
    );
    mups_peer mups_peer_i (
        .clk(CLK), .rst(RST), .tick(TICK), .own_flag(CONTACT_OUT[2]),
        .peer_req(peer_req), .line_idx(line_idx), .di(DI)
    );
    task results;
        $display("mismatches %0d comparisons %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // waits for hready sampled high at a rising edge, bounded
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADYOUT !== 1'h1 && n < 20);
        if (HREADYOUT !== 1'h1) begin
            fail_count++;
            results();
        end
    endtask
    // one single word transfer, entered just after a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        HSEL <= 1'h1;
        HTRANS <= mups_pkg::HTRANS_NONSEQ;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        wait_rdy();
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_rdy();
        rd = HRDATA;
    endtask
    // n control ticks; adv tells whether the last one granted an advance
    task run(input int n);
        repeat (n) begin
            TICK <= 1'h1;
            @(posedge CLK);
            TICK <= 1'h0;
            adv = 1'h0;
            repeat (3) begin
                @(posedge CLK);
                adv = adv | SEG_ADVANCE;
            end
        end
    endtask
    task set_outfn(input logic [12:0] code);
        for (int i = 0; i < 7; i++) begin
            xfer(1'h1, mups_pkg::OFS_OUTFN0 + 8'(4 * i), 32'(code));
        end
    endtask
    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        RST = 1'h1;
        HSEL = 1'h0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'h0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        TICK = 1'h0;
        SEQ = 4'h0;
        peer_req = 1'h0;
        line_idx = 4'h2;
        fail_count = 0;
        checks = 0;
        repeat (20) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        xfer(1'h0, mups_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        xfer(1'h0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        xfer(1'h1, mups_pkg::OFS_WZONE, 32'h00640032);
        xfer(1'h0, mups_pkg::OFS_WZONE, 32'h0);
        chk(rd, 32'h00640032);
        chk({WAIT_ZONE_UP, WAIT_ZONE_LO}, 32'h00640032);
        xfer(1'h1, mups_pkg::OFS_CTRL, 32'h1);
        xfer(1'h1, mups_pkg::OFS_WAIT_SEL, 32'(mups_pkg::CODE_STD_LAST));
        set_outfn(mups_pkg::FN_SEG_FLAG);
        SEQ <= 4'h8;
        run(3);
        chk(RUN_PERMIT, 32'h0);
        chk(CONTACT_OUT, 32'h0);
        run(3);
        chk(RUN_PERMIT, 32'h1);
        chk(WAIT_ENABLE, 32'h1);
        chk(CONTACT_OUT, 32'h7f);
        // segment ends while a peer still waits
        peer_req <= 1'h1;
        SEQ <= 4'hc;
        run(2);
        chk(CONTACT_OUT, 32'h0);
        chk(FORCE_WAIT, 32'h1);
        chk(adv, 32'h0);
        xfer(1'h0, mups_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h00000014);
        chk(HRESP, 32'h0);
        peer_req <= 1'h0;
        run(2);
        chk(adv, 32'h1);
        chk(FORCE_WAIT, 32'h0);
        // continue junction: next segment starts at once and lasts five ticks
        SEQ <= 4'h8;
        run(1);
        chk(CONTACT_OUT, 32'h0);
        run(1);
        chk(CONTACT_OUT, 32'h7f);
        run(3);
        SEQ <= 4'he;
        run(1);
        chk(CONTACT_OUT, 32'h7f);
        chk(adv, 32'h0);
        xfer(1'h1, mups_pkg::OFS_CTRL, 32'h0);
        run(1);
        chk(CONTACT_OUT, 32'h0);
        xfer(1'h1, mups_pkg::OFS_CTRL, 32'h1);
        SEQ <= 4'h0;
        run(1);
        chk(CONTACT_OUT, 32'h0);
        // wait input switched off, then taken from an expansion contact
        SEQ <= 4'hc;
        peer_req <= 1'h1;
        xfer(1'h1, mups_pkg::OFS_WAIT_SEL, 32'(mups_pkg::CODE_OFF));
        run(2);
        chk(adv, 32'h1);
        chk(FORCE_WAIT, 32'h0);
        line_idx <= mups_pkg::IDX_E1_BASE;
        xfer(1'h1, mups_pkg::OFS_WAIT_SEL, 32'(mups_pkg::CODE_E1_FIRST));
        run(2);
        chk(adv, 32'h0);
        chk(FORCE_WAIT, 32'h1);
        line_idx <= 4'hc;
        xfer(1'h1, mups_pkg::OFS_WAIT_SEL, 32'(mups_pkg::CODE_E4_LAST));
        run(2);
        chk(FORCE_WAIT, 32'h1);
        chk(adv, 32'h0);
        // progression mode: hold while any wait flag is up
        peer_req <= 1'h0;
        line_idx <= 4'h2;
        xfer(1'h1, mups_pkg::OFS_WAIT_SEL, 32'(mups_pkg::CODE_OFF));
        xfer(1'h1, mups_pkg::OFS_HOLD_SEL, 32'(mups_pkg::CODE_STD_LAST));
        set_outfn(mups_pkg::FN_WAIT_FLAG);
        SEQ <= 4'h9;
        run(2);
        chk(CONTACT_OUT, 32'h7f);
        chk(FORCE_HOLD, 32'h1);
        SEQ <= 4'h8;
        peer_req <= 1'h1;
        run(2);
        chk(CONTACT_OUT, 32'h0);
        chk(FORCE_HOLD, 32'h1);
        peer_req <= 1'h0;
        run(2);
        chk(FORCE_HOLD, 32'h0);
        results();
    end
endmodule
